// [core/lctg_map.svh]
// lctg_map.svh: timing figures, counts and encodings of the lpddr guard
// assumes the guard clock runs at the period held in LCTG_TCK_PS
`ifndef LCTG_MAP_SVH
`define LCTG_MAP_SVH
// ----------------------------------------------------------------------
// clock and conversion (least times round up, longest times round down)
// ----------------------------------------------------------------------
`define LCTG_TCK_PS        25000
`define LCTG_UP(ns)        (((ns) * 1000 + `LCTG_TCK_PS - 1) / `LCTG_TCK_PS)
`define LCTG_DN(ns)        (((ns) * 1000) / `LCTG_TCK_PS)
// ----------------------------------------------------------------------
// times as printed
// ----------------------------------------------------------------------
`define LCTG_TRCD_F_NS     15
`define LCTG_TRCD_S_NS     18
`define LCTG_TRRD_F_NS     10
`define LCTG_TRRD_S_NS     12
`define LCTG_TRAS_F_NS     40
`define LCTG_TRAS_S_NS     42
`define LCTG_TRAS_MAX_NS   70000
`define LCTG_TWR_NS        15
`define LCTG_TXSR_NS       120
`define LCTG_TRFC_NS       72
`define LCTG_TREFI_US      7.8
`define LCTG_TRP_CK        3
`define LCTG_TWTR_CK       1
`define LCTG_TXP_F_CK      2
`define LCTG_TXP_S_CK      1
`define LCTG_TCKE_CK       1
`define LCTG_TMRD_CK       2
`define LCTG_TSRR_CK       2
`define LCTG_CL2           2
`define LCTG_CL3           3
`define LCTG_BURST_CK      2
// ----------------------------------------------------------------------
// derived cycle counts
// ----------------------------------------------------------------------
`define LCTG_TRCD_F_CYC    `LCTG_UP(`LCTG_TRCD_F_NS)
`define LCTG_TRCD_S_CYC    `LCTG_UP(`LCTG_TRCD_S_NS)
`define LCTG_TRRD_F_CYC    `LCTG_UP(`LCTG_TRRD_F_NS)
`define LCTG_TRRD_S_CYC    `LCTG_UP(`LCTG_TRRD_S_NS)
`define LCTG_TRAS_F_CYC    `LCTG_UP(`LCTG_TRAS_F_NS)
`define LCTG_TRAS_S_CYC    `LCTG_UP(`LCTG_TRAS_S_NS)
`define LCTG_TRAS_MAX_CYC  `LCTG_DN(`LCTG_TRAS_MAX_NS)
`define LCTG_TWR_CYC       `LCTG_UP(`LCTG_TWR_NS)
`define LCTG_TXSR_CYC      `LCTG_UP(`LCTG_TXSR_NS)
`define LCTG_TRFC_CYC      `LCTG_UP(`LCTG_TRFC_NS)
`define LCTG_TREFI_CYC     ($rtoi(`LCTG_TREFI_US * 1.0E6 / `LCTG_TCK_PS))
`define LCTG_TDAL_CYC      (`LCTG_TWR_CYC + `LCTG_TRP_CK)
`define LCTG_RAS_MARGIN_CK 16
// ----------------------------------------------------------------------
// refresh posting, encodings, field positions
// ----------------------------------------------------------------------
`define LCTG_REF_POST_MAX  8
`define LCTG_REF_URGENT    7
`define LCTG_SRR_BA        2'h1
`define LCTG_NUM_BANKS     4
`define LCTG_A10           10
`endif

// [core/lctg_pkg.sv]
// lctg_pkg: types shared by the lpddr command guard and its bank timers
// assumes lctg_map.svh supplies every number used by the logic
package lctg_pkg;
    typedef enum logic [3:0] {
        LCTG_NOP  = 4'h0, LCTG_ACT  = 4'h1, LCTG_RD   = 4'h2,
        LCTG_WR   = 4'h3, LCTG_PRE  = 4'h4, LCTG_PREA = 4'h5,
        LCTG_REF  = 4'h6, LCTG_MRS  = 4'h7, LCTG_PDE  = 4'h8,
        LCTG_SRE  = 4'h9, LCTG_EXIT = 4'hA
    } lctg_cmd_t;
    typedef enum logic [2:0] {
        LCTG_ST_NORM = 3'h1, LCTG_ST_PD = 3'h2, LCTG_ST_SR = 3'h4
    } lctg_state_t;
    typedef struct packed {
        lctg_cmd_t   cmd;
        logic [1:0]  bank;
        logic [12:0] addr;
        logic        ap;
    } lctg_req_t;
    typedef struct packed {
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  ba;
        logic [12:0] addr;
    } lctg_pins_t;
    // per-bank reload values, each already one less than the cycle count
    typedef struct packed {
        logic [3:0] rcd;
        logic [3:0] ras;
        logic [3:0] rp;
        logic [3:0] wpre;
        logic [3:0] rpre;
        logic [3:0] dal;
        logic [3:0] rpa;
    } lctg_btim_t;
    function automatic logic [3:0] dec4(input logic [3:0] v);
        return (v == 4'h0) ? 4'h0 : v - 4'h1;
    endfunction
endpackage

// [core/lctg_bank_timer.sv]
// lctg_bank_timer: spacing counters and open-row age of one bank
// assumes strobes are single-cycle and already legal for this bank
`include "lctg_map.svh"
`timescale 1ns/100ps
`default_nettype none
module lctg_bank_timer (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire lctg_pkg::lctg_btim_t tim,
    input  wire logic                act,
    input  wire logic                pre,
    input  wire logic                rd,
    input  wire logic                wr,
    input  wire logic                ap,
    output logic                     act_ok,
    output logic                     rw_ok,
    output logic                     pre_ok,
    output logic                     open,
    output logic                     due
);
    logic [3:0]  rcd_q;
    logic [3:0]  ras_q;
    logic [3:0]  rp_q;
    logic [3:0]  wp_q;
    logic [3:0]  rp_d;
    logic [3:0]  wp_d;
    logic [3:0]  wp_dec;
    logic [11:0] age_q;
    logic [11:0] age_d;
    logic        open_q;
    logic        open_d;
    logic        age_top;

    // -------------------------------------------------------------
    // next values
    // -------------------------------------------------------------
    assign wp_dec  = lctg_pkg::dec4(wp_q);
    assign rp_d    = pre ? tim.rp : (wr & ap) ? tim.dal :
                     (rd & ap) ? tim.rpa : lctg_pkg::dec4(rp_q);
    assign wp_d    = wr ? tim.wpre :
                     (rd && tim.rpre > wp_dec) ? tim.rpre : wp_dec;
    assign open_d  = act ? 1'h1 : (pre | ((rd | wr) & ap)) ? 1'h0 : open_q;
    assign age_top = (age_q == 12'(`LCTG_TRAS_MAX_CYC));
    assign age_d   = act ? 12'h000 :
                     (open_q & ~age_top) ? age_q + 12'h001 : age_q;

    // spacing counters count down, the age counts up; a reload wins over the count, but a read reloads wp_q only when above its count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rcd_q  <= 4'h0;
            ras_q  <= 4'h0;
            rp_q   <= 4'h0;
            wp_q   <= 4'h0;
            age_q  <= 12'h000;
            open_q <= 1'h0;
        end else begin
            rcd_q  <= act ? tim.rcd : lctg_pkg::dec4(rcd_q);
            ras_q  <= act ? tim.ras : lctg_pkg::dec4(ras_q);
            rp_q   <= rp_d;
            wp_q   <= wp_d;
            age_q  <= age_d;
            open_q <= open_d;
        end
    end

    // -------------------------------------------------------------
    // status toward the scheduler
    // -------------------------------------------------------------
    assign act_ok = ~open_q & (rp_q == 4'h0);
    assign rw_ok  = open_q & (rcd_q == 4'h0);
    assign pre_ok = (ras_q == 4'h0) & (wp_q == 4'h0);
    // close early enough that scheduling slack never passes the limit
    assign due    = open_q & (age_q >= 12'(`LCTG_TRAS_MAX_CYC -
                                          `LCTG_RAS_MARGIN_CK));
    assign open   = open_q;
endmodule
`default_nettype wire

// [core/lctg_guard.sv]
// lctg_guard: lpddr command scheduler that spaces commands to legal gaps
// assumes grade_slow and cas_lat3 are static and come from ref_clk logic
`include "lctg_map.svh"
`timescale 1ns/100ps
`default_nettype none
module lctg_guard (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                grade_slow,
    input  wire logic                cas_lat3,
    input  wire logic                req_valid,
    input  wire lctg_pkg::lctg_req_t req,
    output logic                     req_ready,
    output lctg_pkg::lctg_pins_t     dram,
    output logic                     dqs_oe,
    output logic                     dqs_run,
    output logic                     rd_first,
    output logic                     refresh_due,
    output logic                     refresh_urgent,
    output logic                     clk_change_ok,
    output lctg_pkg::lctg_state_t    pwr_state
);
    lctg_pkg::lctg_btim_t  tim;
    lctg_pkg::lctg_state_t st_q, st_d;
    lctg_pkg::lctg_cmd_t   is_cmd;
    lctg_pkg::lctg_pins_t  pins_q;
    logic [3:0]  b_act_ok, b_rw_ok, b_pre_ok, b_open, b_due;
    logic [15:0] ok_cmd;
    logic [3:0]  gap_q, gap_ld, rrd_q, rfc_q, wtr_q, rtw_q;
    logic [3:0]  ckeh_q, owed_q, cl, rd_pipe_q;
    logic [8:0]  refi_q;
    logic [2:0]  wr_cnt_q;
    logic [1:0]  ub, is_bank, due_idx;
    logic        srr_q, rd_first_q, st_norm, st_pd, gap_ok, cke_ok;
    logic        wr_idle, idle_all, urgent, hold, tick, user_ok;
    logic        a_prea, a_ref, a_pre, a_exit, a_fire;
    logic        f_act, f_rd, f_wr, f_ref, f_mrs, f_pde, f_sre, f_exit;
    logic        cke_d, cke_q_w;

    // -------------------------------------------------------------
    // reload values chosen by speed grade and cas latency
    // -------------------------------------------------------------
    assign cl       = cas_lat3 ? 4'(`LCTG_CL3) : 4'(`LCTG_CL2);
    assign tim.rcd  = grade_slow ? 4'(`LCTG_TRCD_S_CYC - 1)
                                 : 4'(`LCTG_TRCD_F_CYC - 1);
    assign tim.ras  = grade_slow ? 4'(`LCTG_TRAS_S_CYC - 1)
                                 : 4'(`LCTG_TRAS_F_CYC - 1);
    assign tim.rp   = 4'(`LCTG_TRP_CK - 1);
    assign tim.wpre = 4'(`LCTG_BURST_CK + `LCTG_TWR_CYC);
    assign tim.rpre = 4'(`LCTG_BURST_CK - 1);
    assign tim.dal  = 4'(`LCTG_BURST_CK + `LCTG_TDAL_CYC);
    assign tim.rpa  = 4'(`LCTG_BURST_CK + `LCTG_TRP_CK - 1);

    // -------------------------------------------------------------
    // one timer per bank
    // -------------------------------------------------------------
    for (genvar i = 0; i < `LCTG_NUM_BANKS; i++) begin : g_bank
        lctg_bank_timer u_bank (
            .ref_clk (ref_clk),
            .rst_n   (rst_n),
            .tim     (tim),
            .act     (f_act & (is_bank == 2'(i))),
            .pre     (a_prea | (is_cmd == lctg_pkg::LCTG_PREA) |
                      ((is_cmd == lctg_pkg::LCTG_PRE) & (is_bank == 2'(i)))),
            .rd      (f_rd & (is_bank == 2'(i))),
            .wr      (f_wr & (is_bank == 2'(i))),
            .ap      (req.ap),
            .act_ok  (b_act_ok[i]),
            .rw_ok   (b_rw_ok[i]),
            .pre_ok  (b_pre_ok[i]),
            .open    (b_open[i]),
            .due     (b_due[i])
        );
    end

    // -------------------------------------------------------------
    // legality of each command this cycle
    // -------------------------------------------------------------
    assign st_norm  = (st_q == lctg_pkg::LCTG_ST_NORM);
    assign st_pd    = (st_q == lctg_pkg::LCTG_ST_PD);
    assign gap_ok   = (gap_q == 4'h0);
    assign cke_ok   = (ckeh_q == 4'h0);
    assign wr_idle  = (wr_cnt_q == 3'h0);
    assign idle_all = ~|b_open & &b_act_ok;
    assign urgent   = (owed_q >= 4'(`LCTG_REF_URGENT));
    assign hold     = urgent | |b_due;
    assign ub       = req.bank;
    assign ok_cmd[0]  = 1'h1;
    assign ok_cmd[1]  = b_act_ok[ub] & (rrd_q == 4'h0) &
                        (rfc_q == 4'h0);
    // a status read needs every bank idle, not an open row
    assign ok_cmd[2]  = srr_q ? idle_all
                              : b_rw_ok[ub] & (wtr_q == 4'h0);
    assign ok_cmd[3]  = b_rw_ok[ub] & (rtw_q == 4'h0) & wr_idle & ~srr_q;
    assign ok_cmd[4]  = b_pre_ok[ub];
    assign ok_cmd[5]  = &b_pre_ok;
    assign ok_cmd[6]  = idle_all & (rfc_q == 4'h0);
    assign ok_cmd[7]  = idle_all & (rfc_q == 4'h0);
    assign ok_cmd[8]  = cke_ok & wr_idle;
    assign ok_cmd[9]  = idle_all & (rfc_q == 4'h0) & cke_ok;
    assign ok_cmd[15:10] = 6'h00;
    // only exit is legal while the clock enable is low
    assign user_ok = (req.cmd == lctg_pkg::LCTG_NOP) |
                     (st_norm ? gap_ok & ~hold & ok_cmd[req.cmd]
                              : (req.cmd == lctg_pkg::LCTG_EXIT) & cke_ok);

    // -------------------------------------------------------------
    // housekeeping beats the user; the user is stalled meanwhile
    // -------------------------------------------------------------
    assign due_idx = b_due[0] ? 2'h0 : b_due[1] ? 2'h1 :
                     b_due[2] ? 2'h2 : 2'h3;
    assign a_prea  = st_norm & urgent & |b_open & &b_pre_ok & gap_ok;
    assign a_ref   = st_norm & urgent & ok_cmd[6] & gap_ok;
    assign a_pre   = st_norm & ~urgent & |b_due & b_pre_ok[due_idx] &
                     gap_ok;
    assign a_exit  = st_pd & urgent & cke_ok;
    assign a_fire  = a_prea | a_ref | a_pre | a_exit;
    assign req_ready = user_ok & ~a_fire;
    assign is_cmd  = a_prea ? lctg_pkg::LCTG_PREA :
                     a_ref  ? lctg_pkg::LCTG_REF  :
                     a_pre  ? lctg_pkg::LCTG_PRE  :
                     a_exit ? lctg_pkg::LCTG_EXIT :
                     (req_valid & user_ok) ? req.cmd : lctg_pkg::LCTG_NOP;
    assign is_bank = a_pre ? due_idx : req.bank;
    assign f_act   = (is_cmd == lctg_pkg::LCTG_ACT);
    assign f_rd    = (is_cmd == lctg_pkg::LCTG_RD);
    assign f_wr    = (is_cmd == lctg_pkg::LCTG_WR);
    assign f_ref   = (is_cmd == lctg_pkg::LCTG_REF);
    assign f_mrs   = (is_cmd == lctg_pkg::LCTG_MRS);
    assign f_pde   = (is_cmd == lctg_pkg::LCTG_PDE);
    assign f_sre   = (is_cmd == lctg_pkg::LCTG_SRE);
    assign f_exit  = (is_cmd == lctg_pkg::LCTG_EXIT);

    // -------------------------------------------------------------
    // power state and clock enable
    // -------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        case (st_q)
            lctg_pkg::LCTG_ST_NORM: begin
                if (f_pde) begin
                    st_d = lctg_pkg::LCTG_ST_PD;
                end else if (f_sre) begin
                    st_d = lctg_pkg::LCTG_ST_SR;
                end
            end
            lctg_pkg::LCTG_ST_PD,
            lctg_pkg::LCTG_ST_SR: begin
                if (f_exit) begin
                    st_d = lctg_pkg::LCTG_ST_NORM;
                end
            end
            default: st_d = lctg_pkg::LCTG_ST_PD;
        endcase
    end
    assign cke_d = (f_pde | f_sre) ? 1'h0 : f_exit ? 1'h1 : cke_q_w;

    // -------------------------------------------------------------
    // gap to any next command after mode set, status read and exits
    // -------------------------------------------------------------
    assign gap_ld = f_mrs ? 4'(`LCTG_TMRD_CK - 1) :
                    (f_rd & srr_q) ? cl :
                    (f_exit & ~st_pd) ? 4'(`LCTG_TXSR_CYC - 1) :
                    (f_exit & grade_slow) ? 4'(`LCTG_TXP_S_CK - 1) :
                    f_exit ? 4'(`LCTG_TXP_F_CK - 1) : 4'h0;
    assign tick   = (refi_q == 9'(`LCTG_TREFI_CYC - 1));

    // gap counters; each reloads one less than its count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q  <= 4'h0;
            rrd_q  <= 4'h0;
            rfc_q  <= 4'h0;
            wtr_q  <= 4'h0;
            rtw_q  <= 4'h0;
            ckeh_q <= 4'h0;
        end else begin
            gap_q  <= (is_cmd != lctg_pkg::LCTG_NOP) ? gap_ld
                                                 : lctg_pkg::dec4(gap_q);
            rrd_q  <= f_act ? (grade_slow ? 4'(`LCTG_TRRD_S_CYC - 1)
                                          : 4'(`LCTG_TRRD_F_CYC - 1))
                            : lctg_pkg::dec4(rrd_q);
            rfc_q  <= f_ref ? 4'(`LCTG_TRFC_CYC - 1)
                            : lctg_pkg::dec4(rfc_q);
            wtr_q  <= f_wr ? 4'(`LCTG_BURST_CK + `LCTG_TWTR_CK)
                           : lctg_pkg::dec4(wtr_q);
            rtw_q  <= f_rd ? cl + 4'(`LCTG_BURST_CK - 1)
                           : lctg_pkg::dec4(rtw_q);
            ckeh_q <= (cke_d != cke_q_w) ? 4'(`LCTG_TCKE_CK - 1)
                                         : lctg_pkg::dec4(ckeh_q);
        end
    end

    // refresh debt: a tick in the same cycle as a refresh keeps both, unless the debt is 0 (refresh dropped) or LCTG_REF_POST_MAX (tick dropped)
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            refi_q <= 9'h000;
            owed_q <= 4'h0;
            srr_q  <= 1'h0;
            st_q   <= lctg_pkg::LCTG_ST_PD;
        end else begin
            refi_q <= (st_q == lctg_pkg::LCTG_ST_SR || tick) ? 9'h000
                                                         : refi_q + 9'h001;
            owed_q <= (f_sre || st_q == lctg_pkg::LCTG_ST_SR) ? 4'h0 :
                      owed_q
                      + {3'h0, tick & (owed_q != 4'(`LCTG_REF_POST_MAX))}
                      - {3'h0, f_ref & (owed_q != 4'h0)};
            srr_q  <= f_mrs ? (req.bank == `LCTG_SRR_BA)
                            : (f_rd ? 1'h0 : srr_q);
            st_q   <= st_d;
        end
    end

    // -------------------------------------------------------------
    // pin encoding, read data marker, write strobe window
    // -------------------------------------------------------------
    function automatic lctg_pkg::lctg_pins_t enc(
        input lctg_pkg::lctg_cmd_t c,
        input logic [1:0]          ba,
        input logic [12:0]         a,
        input logic                ap,
        input logic                ck);
        lctg_pkg::lctg_pins_t p;
        p = '{ck, 1'h0, 1'h1, 1'h1, 1'h1, ba, a};
        case (c)
            lctg_pkg::LCTG_ACT:  {p.ras_n, p.cas_n, p.we_n} = 3'h3;
            lctg_pkg::LCTG_RD:   {p.ras_n, p.cas_n, p.we_n} = 3'h5;
            lctg_pkg::LCTG_WR:   {p.ras_n, p.cas_n, p.we_n} = 3'h4;
            lctg_pkg::LCTG_PRE:  {p.ras_n, p.cas_n, p.we_n} = 3'h2;
            lctg_pkg::LCTG_PREA: {p.ras_n, p.cas_n, p.we_n} = 3'h2;
            lctg_pkg::LCTG_REF,
            lctg_pkg::LCTG_SRE:  {p.ras_n, p.cas_n, p.we_n} = 3'h1;
            lctg_pkg::LCTG_MRS:  {p.ras_n, p.cas_n, p.we_n} = 3'h0;
            default:             {p.ras_n, p.cas_n, p.we_n} = 3'h7;
        endcase
        if (c == lctg_pkg::LCTG_RD || c == lctg_pkg::LCTG_WR) begin
            p.addr[`LCTG_A10] = ap;
        end else if (c == lctg_pkg::LCTG_PRE || c == lctg_pkg::LCTG_PREA) begin
            p.addr[`LCTG_A10] = (c == lctg_pkg::LCTG_PREA);
        end
        return p;
    endfunction

    assign cke_q_w = pins_q.cke;

    // pins from flops; the marker follows the read by cl plus one edges
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_q     <= '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0, 13'h0000};
            rd_pipe_q  <= 4'h0;
            rd_first_q <= 1'h0;
            wr_cnt_q   <= 3'h0;
        end else begin
            pins_q     <= enc(is_cmd, is_bank, req.addr,
                              req.ap & ~a_fire, cke_d);
            rd_pipe_q  <= {rd_pipe_q[2:0], f_rd};
            rd_first_q <= rd_pipe_q[cl[1:0]];
            wr_cnt_q   <= f_wr ? 3'(`LCTG_BURST_CK + 1)
                               : (wr_idle ? 3'h0 : wr_cnt_q - 3'h1);
        end
    end

    assign dram           = pins_q;
    assign rd_first       = rd_first_q;
    // preamble: strobe driven low a full cycle before it starts to run
    assign dqs_oe         = ~wr_idle;
    assign dqs_run        = ~wr_idle &
                            (wr_cnt_q <= 3'(`LCTG_BURST_CK));
    assign refresh_due    = (owed_q != 4'h0);
    assign refresh_urgent = urgent;
    assign clk_change_ok  = ~st_norm;
    assign pwr_state      = st_q;
endmodule
`default_nettype wire

// [core/lctg_pad_end.sv]
`timescale 1ns/100ps

// [test/lctg_guard_chk.sv]
// lctg_guard_chk: spacing of commands seen on the guard's memory pins
// assumes it is bound into every lctg_guard instance
`timescale 1ns/100ps
`default_nettype none
module lctg_guard_chk (
    input wire logic                  ref_clk,
    input wire logic                  rst_n,
    input wire logic                  grade_slow,
    input wire logic                  cas_lat3,
    input wire lctg_pkg::lctg_pins_t  dram,
    input wire logic                  dqs_oe,
    input wire logic                  dqs_run,
    input wire logic                  rd_first,
    input wire logic                  clk_change_ok,
    input wire lctg_pkg::lctg_state_t pwr_state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // pin decode; deselect and nop both count as no command
    wire logic [2:0] rcw = {dram.ras_n, dram.cas_n, dram.we_n};
    wire logic any = !dram.cs_n && rcw != 3'h7;
    wire logic act = any && rcw == 3'h3;
    wire logic rd = any && rcw == 3'h5;
    wire logic wr = any && rcw == 3'h4;
    wire logic pre = any && rcw == 3'h2;
    wire logic rf = any && rcw == 3'h1 && dram.cke;
    wire logic mrs = any && rcw == 3'h0;
    sequence s_srr; mrs && dram.ba == 2'h1 ##2 rd; endsequence
    sequence s_wburst; (dqs_oe && dqs_run) [*2] ##1 !dqs_oe; endsequence
    // one-clock cke pulses are legal; a level change must match the state
    property p_cke;
        $changed(dram.cke) |-> dram.cke == (pwr_state ==
                                            lctg_pkg::LCTG_ST_NORM);
    endproperty
    a_cke: assert property (p_cke) else $error("cke out of step");
    // a rate change is only offered while the memory is parked
    property p_clk; clk_change_ok |-> !dram.cke; endproperty
    a_clk: assert property (p_clk) else $error("rate change open");
    property p_actpre; act |=> !pre; endproperty
    a_actpre: assert property (p_actpre) else $error("row closed early");
    property p_wrpre; wr |=> !pre [*3]; endproperty
    a_wrpre: assert property (p_wrpre) else $error("write recovery short");
    property p_ref; rf |=> !(act || rf) [*2]; endproperty
    a_ref: assert property (p_ref) else $error("refresh gap short");
    property p_mrs; mrs |=> !any; endproperty
    a_mrs: assert property (p_mrs) else $error("mode set gap short");
    // status read keeps the bus quiet for cas latency cycles
    property p_srr; s_srr |=> !any [*2] ##1 (!cas_lat3 || !any); endproperty
    a_srr: assert property (p_srr) else $error("status read gap");
    property p_rd; rd |-> if (cas_lat3) ##4 rd_first else ##3 rd_first;
    endproperty
    a_rd: assert property (p_rd) else $error("read data slot wrong");
    property p_wrq; wr |-> dqs_oe && !dqs_run ##1 s_wburst; endproperty
    a_wrq: assert property (p_wrq) else $error("write strobe wrong");
    property p_pdx; $rose(dram.cke) && !grade_slow |=> !any; endproperty
    a_pdx: assert property (p_pdx) else $error("exit gap short");
endmodule
bind lctg_guard lctg_guard_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .grade_slow(grade_slow), .cas_lat3(cas_lat3), .dram(dram),
    .dqs_oe(dqs_oe), .dqs_run(dqs_run), .rd_first(rd_first),
    .clk_change_ok(clk_change_ok), .pwr_state(pwr_state));
`default_nettype wire

// [test/lctg_dev_model.sv]
// lctg_dev_model: memory side, marks when first read data is valid
// assumes pins are sampled on the rising edge as the memory does
`timescale 1ns/100ps
`default_nettype none
module lctg_dev_model (
    input wire logic                 ref_clk,
    input wire logic                 rst_n,
    input wire logic                 cas_lat3,
    input wire lctg_pkg::lctg_pins_t dram,
    output logic                     data_valid
);
    logic [3:0] age_q;
    wire logic rd = dram.cke && !dram.cs_n && dram.ras_n && !dram.cas_n
                    && dram.we_n;
    // age of each read; no dq bus here, only the valid slot
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) age_q <= 4'h0;
        else age_q <= {age_q[2:0], rd};
    end
    assign data_valid = cas_lat3 ? age_q[3] : age_q[2];
endmodule
`default_nettype wire

// [test/lctg_guard_tb.sv]
// lctg_guard_tb: command table through the guard, pins and gaps checked
// assumes the fast grade and cas latency 3 throughout
`timescale 1ns/100ps
`default_nettype none
module lctg_guard_tb;
    logic ref_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
    logic [31:0] lfsr_q = 32'h0001212C;
    logic [1:0] bk;
    lctg_pkg::lctg_req_t req = '0;
    lctg_pkg::lctg_pins_t dram;
    lctg_pkg::lctg_state_t pwr_state;
    logic req_ready, dqs_oe, dqs_run, rd_first, refresh_due, clk_ok, dv, urg;
    int failures = 0, check_count = 0, cyc = 0, last = 0;
    logic [2:0] enc [11] = '{3'h7,3'h3,3'h5,3'h4,3'h2,3'h2,3'h1,3'h0,3'h7,3'h1,3'h7};
    logic [3:0] cmd [18] = '{4'hA,4'h7,4'h2,4'h1,4'h3,4'h4,4'h1,4'h2,4'h4,
                             4'h6,4'h1,4'h4,4'h8,4'hA,4'h9,4'hA,4'h1,4'h4};
    int gap [18] = '{0,2,2,4,1,4,3,1,2,3,3,2,1,1,2,1,5,2};
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    lctg_guard dut (.ref_clk, .rst_n, .grade_slow(1'b0), .cas_lat3(1'b1),
        .req_valid, .req, .req_ready, .dram, .dqs_oe, .dqs_run, .rd_first,
        .refresh_due, .refresh_urgent(urg), .clk_change_ok(clk_ok),
        .pwr_state);
    lctg_dev_model dev (.ref_clk, .rst_n, .cas_lat3(1'b1), .dram, .data_valid(dv));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // request held until taken; gap counted between taking edges
    task automatic issue(input logic [3:0] c, input int g);
        int n = 0;
        @(negedge ref_clk);
        lfsr_q = lfsr(lfsr_q);
        req_valid = 1'b1;
        req = '{lctg_pkg::lctg_cmd_t'(c), (c == 4'h7) ? 2'h1 : bk,
                lfsr_q[12:0], 1'b0};
        // let ready settle on the new request before it is read
        #1;
        while (!req_ready && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        check(n < 400 && cyc - last >= g, 1'b1);
        last = cyc;
        #1;
        check({dram.cke, dram.cs_n, dram.ras_n, dram.cas_n, dram.we_n},
              {!(c == 4'h8 || c == 4'h9), 1'b0, enc[c]});
        if (c inside {1, 2, 3, 7}) check(dram.ba, req.bank);
        check({pwr_state, clk_ok}, (c == 4'h8) ? 4'h5 : (c == 4'h9) ? 4'h9 : 4'h2);
    endtask
    // device read slot compared with the guard's capture pulse
    always @(negedge ref_clk) if (rst_n) check(rd_first, dv);
    initial begin
        #100000;
        failures++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        check({dram.cke, pwr_state, clk_ok}, 5'h05);
        @(negedge ref_clk) rst_n = 1'b1;
        bk = lfsr_q[1:0];
        for (int i = 0; i < 18; i++) issue(cmd[i], gap[i]);
        @(negedge ref_clk) req_valid = 1'b0;
        $display("command table done");
        for (int n = 0; n < 400 && refresh_due !== 1'b1; n++) @(negedge ref_clk);
        check({refresh_due, urg}, 2'h2);
        issue(4'h6, 0);
        @(negedge ref_clk) req_valid = 1'b0;
        check(refresh_due, 1'b0);
        $display("refresh test done");
        test_done();
    end
endmodule
`default_nettype wire
